// ### shared/apw_pkg.sv
// Package of register map, field positions, reset values and timing for the PME and wake control block
`default_nettype none
package apw_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_KBD_INDEX  = 8'hE1;
  localparam logic [7:0] IDX_KBD_DATA   = 8'hE2;
  localparam logic [7:0] IDX_POLICY     = 8'hE4;
  localparam logic [7:0] IDX_WAKE_SEL   = 8'hE7;
  localparam logic [7:0] IDX_GLOBAL     = 8'hF2;
  localparam logic [7:0] IDX_STAT_ONE   = 8'hF3;
  localparam logic [7:0] IDX_STAT_TWO   = 8'hF4;
  localparam logic [7:0] IDX_EN_ONE     = 8'hF6;
  localparam logic [7:0] IDX_EN_TWO     = 8'hF7;
  localparam logic [7:0] IDX_ROUTE      = 8'hFE;
  localparam logic [7:0] IDX_CTRL       = 8'h10;
  localparam logic [7:0] IDX_IRQ_STAT   = 8'h11;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h12;
  // Field positions of the wake and reset select register
  localparam int BIT_KSET_THREE = 7;
  localparam int BIT_KSET_TWO   = 6;
  localparam int BIT_OS_KEY     = 5;
  localparam int BIT_DELAY_PSW  = 4;
  localparam int BIT_WDT_SRC    = 3;
  localparam int BIT_HWM_SRC    = 0;
  localparam logic [7:0] WAKE_SEL_MASK = 8'hF9;
  // Policy field and code
  localparam int POLICY_LSB = 5;
  localparam logic [1:0] POLICY_ALWAYS_ON = 2'h1;
  // Route field positions
  localparam int ROUTE_PSW_LSB = 4;
  localparam int ROUTE_PME_LSB = 0;
  // Reset values
  localparam logic [7:0] RST_WAKE_SEL = 8'h00;
  localparam logic [7:0] RST_GLOBAL   = 8'h3E;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  // Keyboard wake storage: set two at 30h, set three at 40h, 15 entries each
  localparam int KSET_NUM   = 2;
  localparam int KSET_DEPTH = 15;
  localparam logic [3:0] KSET_TWO_BASE   = 4'h3;
  localparam logic [3:0] KSET_THREE_BASE = 4'h4;
  // Interrupt status bits
  localparam int IRQ_PME   = 0;
  localparam int IRQ_PSW   = 1;
  localparam int IRQ_MATCH = 2;
  localparam int IRQ_NUM   = 3;
  // Timing
  localparam longint CLK_HZ       = 50_000_000;
  localparam longint PSW_DELAY_MS = 500;
  localparam longint PSW_PULSE_NS = 2000;
  localparam longint PSW_DELAY_CYC = CLK_HZ * PSW_DELAY_MS / 1000;
  localparam longint PSW_PULSE_CYC = CLK_HZ / 1000 * PSW_PULSE_NS / 1_000_000;
  // Power switch sequencer states
  typedef enum logic [1:0] {
    PSW_IDLE  = 2'b00,
    PSW_WAIT  = 2'b01,
    PSW_DRIVE = 2'b10
  } apw_psw_state_t;
endpackage : apw_pkg
`default_nettype wire

// ### verilog/apw_key_matcher.sv
// Sequence matcher for one keyboard wake key combination
`default_nettype none
module apw_key_matcher
  import apw_pkg::*;
#(
  parameter int DEPTH = KSET_DEPTH
)
(
  // Clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  // Control and stored combination
  input  wire logic               enable_i,
  input  wire logic [DEPTH*8-1:0] seq_i,
  // Incoming key codes
  input  wire logic               code_valid_i,
  input  wire logic [7:0]         code_i,
  // Match pulse
  output logic                    match_o
);
  initial
  begin
    if (DEPTH < 1 || DEPTH > 15)
      $error("apw_key_matcher: DEPTH out of range");
  end

  logic [3:0] pos;
  logic [3:0] pos_up;
  logic [7:0] want;
  logic [7:0] next_want;

  // A zero entry ends the combination, so short sequences need no length field
  assign pos_up    = pos + 4'h1;
  assign want      = seq_i[8*pos +: 8];
  assign next_want = (pos_up < 4'(DEPTH)) ? seq_i[8*pos_up +: 8] : 8'h00;

  // Walk the stored sequence; a mismatch restarts, counting the code as a new start when it equals the first entry
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || !enable_i)
    begin
      pos     <= 4'h0;
      match_o <= 1'b0;
    end
    else
    begin
      match_o <= 1'b0;
      if (code_valid_i && seq_i[7:0] != 8'h00)
      begin
        if (code_i == want)
        begin
          if (next_want == 8'h00)
          begin
            pos     <= 4'h0;
            match_o <= 1'b1;
          end
          else
            pos <= pos_up;
        end
        else
          pos <= (code_i == seq_i[7:0]) ? 4'h1 : 4'h0;
      end
    end
  end
endmodule : apw_key_matcher
`default_nettype wire

// ### verilog/apw_psw_gen.sv
// Power switch output sequencer with optional start delay
`default_nettype none
module apw_psw_gen
  import apw_pkg::*;
#(
  parameter int DELAY_CYC = 32'(PSW_DELAY_CYC),
  parameter int PULSE_CYC = 32'(PSW_PULSE_CYC)
)
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Triggers
  input  wire logic now_i,
  input  wire logic delayed_i,
  // Outputs
  output logic      psw_n_o,
  output logic      start_o,
  output logic      idle_o
);
  initial
  begin
    if (DELAY_CYC < 2 || PULSE_CYC < 1)
      $error("apw_psw_gen: counts too small");
  end

  apw_psw_state_t state;
  logic [31:0]    cnt;

  assign psw_n_o = (state != PSW_DRIVE);
  assign idle_o  = (state == PSW_IDLE);

  // Triggers while busy are dropped; one press makes one pulse
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state   <= PSW_IDLE;
      cnt     <= 32'h0;
      start_o <= 1'b0;
    end
    else
    begin
      start_o <= 1'b0;
      case (state)
        PSW_IDLE:
        begin
          if (now_i)
          begin
            state   <= PSW_DRIVE;
            cnt     <= 32'(PULSE_CYC - 1);
            start_o <= 1'b1;
          end
          else if (delayed_i)
          begin
            state <= PSW_WAIT;
            cnt   <= 32'(DELAY_CYC - 2);
          end
        end
        PSW_WAIT:
        begin
          if (cnt == 32'h0)
          begin
            state   <= PSW_DRIVE;
            cnt     <= 32'(PULSE_CYC - 1);
            start_o <= 1'b1;
          end
          else
            cnt <= cnt - 32'h1;
        end
        PSW_DRIVE:
        begin
          if (cnt == 32'h0)
            state <= PSW_IDLE;
          else
            cnt <= cnt - 32'h1;
        end
        default:
          state <= PSW_IDLE;
      endcase
    end
  end
endmodule : apw_psw_gen
`default_nettype wire

// ### verilog/apw_top.sv
// PME, wake and reset-source control with APB register access
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module apw_top
  import apw_pkg::*;
#(
  parameter int PSW_DELAY = 32'(PSW_DELAY_CYC),
  parameter int PSW_PULSE = 32'(PSW_PULSE_CYC)
)
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [9:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Source interrupts, first group bits 6..0: uart_c, mouse, keyboard_controller, printer, floppy, uart_a, uart_b
  input  wire logic [6:0]  src_one_i,
  // Second group bits 5..0: uart_f, uart_e, hardware_monitor, watchdog_timeout, uart_d, ring_indicate_b
  input  wire logic [5:0]  src_two_i,
  // Event pulses of gen_input_27, 26, 25 in bits 2..0
  input  wire logic [2:0]  gen_input_evt_i,
  // Keyboard wake
  input  wire logic        key_valid_i,
  input  wire logic [7:0]  key_code_i,
  input  wire logic        os_key_i,
  // Power return pulse
  input  wire logic        power_return_i,
  // Reset sources
  input  wire logic        bus_reset_in_n_i,
  input  wire logic        power_good_i,
  // Outputs
  output logic             pme_n_o,
  output logic             power_switch_out_n_o,
  output logic             wdt_reset_o,
  output logic             hwm_reset_o,
  output logic             irq_o
);
  initial
  begin
    if (PSW_DELAY < PSW_PULSE + 2)
      $error("apw_top: PSW_DELAY too small");
  end

  // Register state
  logic [7:0]         wake_and_reset_select;
  logic               pme_global_on;
  logic [6:0]         pme_status_first;
  logic [5:0]         pme_status_second;
  logic [6:0]         pme_enable_first;
  logic [5:0]         pme_enable_second;
  logic [7:0]         gpio_event_route;
  logic [1:0]         power_loss_policy;
  logic [7:0]         kbd_wake_index_reg;
  logic               kbd_wake_on;
  logic [IRQ_NUM-1:0] irq_status;
  logic [IRQ_NUM-1:0] irq_mask;
  logic [7:0]         kmem [KSET_NUM][KSET_DEPTH];

  // Bus decode
  logic       setup_ph;
  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] idx;
  logic       mapped;
  logic [7:0] rd_mux;
  logic [7:0] kdata_rd;
  logic [IRQ_NUM-1:0] irq_seen;

  assign idx      = paddr_i[9:2];
  assign setup_ph = psel_i && !penable_i;
  assign wr_acc   = psel_i && penable_i && pwrite_i;
  assign rd_acc   = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;

  // Address map
  always_comb
  begin
    mapped = 1'b1;
    case (idx)
      IDX_KBD_INDEX, IDX_KBD_DATA, IDX_POLICY, IDX_WAKE_SEL, IDX_GLOBAL,
      IDX_STAT_ONE, IDX_STAT_TWO, IDX_EN_ONE, IDX_EN_TWO, IDX_ROUTE,
      IDX_CTRL, IDX_IRQ_STAT, IDX_IRQ_MASK:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  assign pslverr_o = psel_i && penable_i && !mapped;

  // Indirect keyboard wake data at the current index
  always_comb
  begin
    kdata_rd = 8'h00;
    if (kbd_wake_index_reg[3:0] != 4'hF)
    begin
      if (kbd_wake_index_reg[7:4] == KSET_TWO_BASE)
        kdata_rd = kmem[0][kbd_wake_index_reg[3:0]];
      else if (kbd_wake_index_reg[7:4] == KSET_THREE_BASE)
        kdata_rd = kmem[1][kbd_wake_index_reg[3:0]];
    end
  end

  // Read mux; reserved bits of the global register read their default
  always_comb
  begin
    case (idx)
      IDX_KBD_INDEX: rd_mux = kbd_wake_index_reg;
      IDX_KBD_DATA:  rd_mux = kdata_rd;
      IDX_POLICY:    rd_mux = {1'b0, power_loss_policy, 5'h00};
      IDX_WAKE_SEL:  rd_mux = wake_and_reset_select;
      IDX_GLOBAL:    rd_mux = {RST_GLOBAL[7:1], pme_global_on};
      IDX_STAT_ONE:  rd_mux = {1'b0, pme_status_first};
      IDX_STAT_TWO:  rd_mux = {2'h0, pme_status_second};
      IDX_EN_ONE:    rd_mux = {1'b0, pme_enable_first};
      IDX_EN_TWO:    rd_mux = {2'h0, pme_enable_second};
      IDX_ROUTE:     rd_mux = gpio_event_route;
      IDX_CTRL:      rd_mux = {7'h00, kbd_wake_on};
      IDX_IRQ_STAT:  rd_mux = {5'h00, irq_status};
      IDX_IRQ_MASK:  rd_mux = {5'h00, irq_mask};
      default:       rd_mux = 8'h00;
    endcase
  end

  // Read data is captured in the setup phase so the access phase answers at once
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      prdata_o <= 32'h0;
    else if (setup_ph && !pwrite_i)
      prdata_o <= {24'h000000, rd_mux};
  end

  // Control registers
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      wake_and_reset_select <= RST_WAKE_SEL;
      pme_global_on         <= RST_GLOBAL[0];
      pme_enable_first      <= RST_ZERO[6:0];
      pme_enable_second     <= RST_ZERO[5:0];
      gpio_event_route      <= RST_ZERO;
      power_loss_policy     <= RST_ZERO[1:0];
      kbd_wake_index_reg    <= RST_ZERO;
      kbd_wake_on           <= 1'b0;
      irq_mask              <= RST_ZERO[IRQ_NUM-1:0];
    end
    else if (wr_acc)
    begin
      case (idx)
        IDX_KBD_INDEX: kbd_wake_index_reg    <= pwdata_i[7:0];
        IDX_POLICY:    power_loss_policy     <= pwdata_i[POLICY_LSB +: 2];
        IDX_WAKE_SEL:  wake_and_reset_select <= pwdata_i[7:0] & WAKE_SEL_MASK;
        IDX_GLOBAL:    pme_global_on         <= pwdata_i[0];
        IDX_EN_ONE:    pme_enable_first      <= pwdata_i[6:0];
        IDX_EN_TWO:    pme_enable_second     <= pwdata_i[5:0];
        IDX_ROUTE:     gpio_event_route      <= pwdata_i[7:0] & 8'h77;
        IDX_CTRL:      kbd_wake_on           <= pwdata_i[0];
        IDX_IRQ_MASK:  irq_mask              <= pwdata_i[IRQ_NUM-1:0];
        default:       kbd_wake_on           <= kbd_wake_on;
      endcase
    end
  end

  // Key combination storage and matchers, one per set
  logic [KSET_NUM-1:0] kset_on;
  logic [KSET_NUM-1:0] kset_match;
  assign kset_on = {wake_and_reset_select[BIT_KSET_THREE], wake_and_reset_select[BIT_KSET_TWO]};

  genvar s;
  generate
    for (s = 0; s < KSET_NUM; s++)
    begin : g_kset
      logic [KSET_DEPTH*8-1:0] flat;
      logic                    hit;
      // Set two lives at 30h..3Eh, set three at 40h..4Eh
      assign hit = (kbd_wake_index_reg[7:4] == ((s == 0) ? KSET_TWO_BASE : KSET_THREE_BASE))
                   && (kbd_wake_index_reg[3:0] != 4'hF);
      for (genvar e = 0; e < KSET_DEPTH; e++)
      begin : g_entry
        assign flat[8*e +: 8] = kmem[s][e];
        always_ff @(posedge core_clk_i)
        begin
          if (rst_i)
            kmem[s][e] <= 8'h00;
          else if (wr_acc && idx == IDX_KBD_DATA && hit && kbd_wake_index_reg[3:0] == 4'(e))
            kmem[s][e] <= pwdata_i[7:0];
        end
      end
      // Matching only runs while the set is enabled and keyboard wake is on
      apw_key_matcher #(
        .DEPTH (KSET_DEPTH)
      ) u_match (
        .core_clk_i   (core_clk_i),
        .rst_i        (rst_i),
        .enable_i     (kset_on[s] && kbd_wake_on),
        .seq_i        (flat),
        .code_valid_i (key_valid_i),
        .code_i       (key_code_i),
        .match_o      (kset_match[s])
      );
    end
  endgenerate

  // Rising edges of source interrupts are the events
  logic [6:0] src_one_q;
  logic [5:0] src_two_q;
  logic [6:0] evt_one;
  logic [5:0] evt_two;
  logic [6:0] clr_one;
  logic [5:0] clr_two;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      src_one_q <= 7'h00;
      src_two_q <= 6'h00;
    end
    else
    begin
      src_one_q <= src_one_i;
      src_two_q <= src_two_i;
    end
  end

  assign evt_one = src_one_i & ~src_one_q;
  assign evt_two = src_two_i & ~src_two_q;
  assign clr_one = (wr_acc && idx == IDX_STAT_ONE) ? pwdata_i[6:0] : 7'h00;
  assign clr_two = (wr_acc && idx == IDX_STAT_TWO) ? pwdata_i[5:0] : 6'h00;

  // Sticky status; the set term is applied after the clear so it wins
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pme_status_first  <= 7'h00;
      pme_status_second <= 6'h00;
    end
    else
    begin
      pme_status_first  <= (pme_status_first & ~clr_one) | evt_one;
      pme_status_second <= (pme_status_second & ~clr_two) | evt_two;
    end
  end

  // PME output; a routed general input only asserts it for its event cycle
  logic pme_cause;
  assign pme_cause = |(pme_status_first & pme_enable_first)
                   | |(pme_status_second & pme_enable_second)
                   | |(gen_input_evt_i & gpio_event_route[ROUTE_PME_LSB +: 3]);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      pme_n_o <= 1'b1;
    else
      pme_n_o <= !(pme_global_on && pme_cause);
  end

  // Power switch triggers
  logic psw_now;
  logic psw_delayed;
  logic psw_start;
  logic psw_idle;
  logic os_wake;
  logic policy_on;

  assign os_wake     = os_key_i && wake_and_reset_select[BIT_OS_KEY] && kbd_wake_on;
  assign policy_on   = (power_loss_policy == POLICY_ALWAYS_ON);
  assign psw_delayed = power_return_i && policy_on && wake_and_reset_select[BIT_DELAY_PSW];
  assign psw_now     = os_wake || (|kset_match)
                     || |(gen_input_evt_i & gpio_event_route[ROUTE_PSW_LSB +: 3])
                     || (power_return_i && policy_on && !wake_and_reset_select[BIT_DELAY_PSW]);

  apw_psw_gen #(
    .DELAY_CYC (PSW_DELAY),
    .PULSE_CYC (PSW_PULSE)
  ) u_psw (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .now_i      (psw_now),
    .delayed_i  (psw_delayed),
    .psw_n_o    (power_switch_out_n_o),
    .start_o    (psw_start),
    .idle_o     (psw_idle)
  );

  // Reset source selection, registered to keep the outputs glitch free
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      wdt_reset_o <= 1'b0;
      hwm_reset_o <= 1'b0;
    end
    else
    begin
      wdt_reset_o <= wake_and_reset_select[BIT_WDT_SRC] ? !power_good_i : !bus_reset_in_n_i;
      hwm_reset_o <= wake_and_reset_select[BIT_HWM_SRC] ? !bus_reset_in_n_i : !power_good_i;
    end
  end

  // Interrupt status; a read clears only the bits it returned
  logic pme_n_q;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      irq_status <= '0;
      irq_seen   <= '0;
      pme_n_q    <= 1'b1;
    end
    else
    begin
      pme_n_q <= pme_n_o;
      if (setup_ph && !pwrite_i && idx == IDX_IRQ_STAT)
        irq_seen <= irq_status;
      irq_status <= (irq_status & ~((rd_acc && idx == IDX_IRQ_STAT) ? irq_seen : '0))
                  | {(|kset_match), psw_start, (pme_n_q && !pme_n_o)};
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_PME_GATE: assert property (!pme_global_on |=> pme_n_o)
    else $error("PME asserted while globally off");
  AST_PME_DRIVE: assert property (pme_global_on && |(pme_status_second & pme_enable_second) |=> !pme_n_o)
    else $error("PME not asserted for enabled flag");
  AST_EN_ONE_MASK: assert property ((pme_status_first & pme_enable_first) == 7'h00
      && (pme_status_second & pme_enable_second) == 6'h00 && gen_input_evt_i == 3'h0 |=> pme_n_o)
    else $error("PME asserted with no enabled cause");
  AST_STAT_ONE_SET: assert property (|evt_one |=> (pme_status_first & $past(evt_one)) == $past(evt_one))
    else $error("first status event lost");
  AST_STAT_TWO_HOLD: assert property (clr_two == 6'h00
      |=> (pme_status_second & $past(pme_status_second)) == $past(pme_status_second))
    else $error("second status flag dropped without clear");
  AST_STAT_TWO_W1C: assert property (wr_acc && idx == IDX_STAT_TWO && pwdata_i[0] && !evt_two[0]
      |=> !pme_status_second[0])
    else $error("second status flag not cleared by write one");
  AST_OS_KEY: assert property (os_wake && psw_idle |=> !power_switch_out_n_o)
    else $error("OS wake key did not drive power switch");
  AST_GPIO_PSW: assert property (gen_input_evt_i[2] && gpio_event_route[6] && psw_idle
      |=> !power_switch_out_n_o)
    else $error("routed input did not drive power switch");
  AST_DELAY: assert property (psw_delayed && !psw_now && psw_idle |=> power_switch_out_n_o [*8])
    else $error("delayed power switch came early");
  AST_WDT_SRC: assert property (wake_and_reset_select[BIT_WDT_SRC] && !power_good_i |=> wdt_reset_o)
    else $error("watchdog reset source wrong");
  AST_HWM_SRC: assert property (!wake_and_reset_select[BIT_HWM_SRC] && !power_good_i |=> hwm_reset_o)
    else $error("monitor reset source wrong");
endmodule : apw_top
`default_nettype wire

// ### tb/apw_host_model.sv
// Host-side watcher of the power switch and PME outputs
`default_nettype none
module apw_host_model
(
  // Clock and device outputs
  input  wire logic core_clk_i,
  input  wire logic psw_n_i,
  input  wire logic pme_n_i,
  // Measurements for the bench
  output int        cyc_o,
  output int        falls_o,
  output int        fall_at_o,
  output int        width_o,
  output int        pme_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev;
  // Start clean; the device holds both outputs high through reset
  initial
  begin
    {cyc_o, falls_o, fall_at_o, width_o, pme_low_o} = '0;
    prev = 1'b1;
  end
  // Sample each edge; the edge count is the time base for delay checks
  always @(posedge core_clk_i)
  begin
    cyc_o <= cyc_o + 1;
    prev <= psw_n_i;
    if (pme_n_i === 1'b0)
      pme_low_o <= pme_low_o + 1;
    if (prev && psw_n_i === 1'b0)
    begin
      falls_o <= falls_o + 1;
      fall_at_o <= cyc_o;
      width_o <= 1;
    end
    else if (psw_n_i === 1'b0)
      width_o <= width_o + 1;
  end
endmodule : apw_host_model
`default_nettype wire

// ### tb/acpi_pme_wake_control_test.sv
// Self-checking bench for the PME, wake and reset-source block
`default_nettype none
module acpi_pme_wake_control_test;
  import apw_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 40;
  localparam int PUL = 4;
  logic        clk, rst, psel, pen, pwr, pready, pslverr, pme_n, psw_n, wdt_r, hwm_r, irq;
  logic        kv, osk, pret, brst_n, pgood, err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  src1;
  logic [5:0]  src2;
  logic [2:0]  gev;
  logic [7:0]  kcode, rd, v, v2;
  // Registers that must read zero straight after reset
  localparam logic [7:0] ZERO_IDX [5] = '{IDX_STAT_ONE, IDX_STAT_TWO, IDX_EN_ONE, IDX_EN_TWO, IDX_ROUTE};
  logic [7:0]  lfsr = 8'h52;
  int          fail_count, samples_checked, cyc, falls, fall_at, width, pmel, t0, n;
  apw_top #(.PSW_DELAY(DLY), .PSW_PULSE(PUL)) apw_top_inst (.core_clk_i(clk), .rst_i(rst),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .src_one_i(src1), .src_two_i(src2),
    .gen_input_evt_i(gev), .key_valid_i(kv), .key_code_i(kcode), .os_key_i(osk),
    .power_return_i(pret), .bus_reset_in_n_i(brst_n), .power_good_i(pgood), .pme_n_o(pme_n),
    .power_switch_out_n_o(psw_n), .wdt_reset_o(wdt_r), .hwm_reset_o(hwm_r), .irq_o(irq));
  apw_host_model apw_host_model_inst (.core_clk_i(clk), .psw_n_i(psw_n), .pme_n_i(pme_n),
    .cyc_o(cyc), .falls_o(falls), .fall_at_o(fall_at), .width_o(width), .pme_low_o(pmel));
  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Fixed-seed byte source
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= {idx, 2'b00}; pwdata <= {24'h0, wd};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    // A slave that never answers ends the run as a failure
    if (pready !== 1'b1)
    begin
      fail_count++;
      wrap_up();
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rchk
  // Waits for a power switch pulse and checks its start and length
  task automatic psw_chk(input int lag);
    repeat (lag + PUL + 4) @(posedge clk);
    chk(fall_at - t0, lag);
    chk(width, PUL);
  endtask : psw_chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Hang guard, well beyond the expected run
  initial
  begin
    #400000;
    fail_count++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    {rst, psel, pen, pwr, paddr, pwdata, src1, src2, gev, kv, kcode, osk, pret} = '0;
    rst = 1'b1; brst_n = 1'b1; pgood = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(IDX_WAKE_SEL, 8'h00);
    rchk(IDX_GLOBAL, 8'h3E);
    foreach (ZERO_IDX[i])
      rchk(ZERO_IDX[i], 8'h00);
    apb(1'b0, 8'h20, 8'h00);
    chk(err, 1'b1);
    // Random data through the plain registers; reserved bits read 0, or their default in the global register
    v = rnd(); apb(1'b1, IDX_EN_ONE, v); rchk(IDX_EN_ONE, v & 8'h7F);
    v = rnd(); apb(1'b1, IDX_EN_TWO, v); rchk(IDX_EN_TWO, v & 8'h3F);
    v = rnd(); apb(1'b1, IDX_ROUTE, v); rchk(IDX_ROUTE, v & 8'h77);
    v = rnd(); apb(1'b1, IDX_GLOBAL, v); rchk(IDX_GLOBAL, 8'h3E | (v & 8'h01));
    // Every select setting against every reset-input level
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b1, IDX_WAKE_SEL, {4'h0, i[1], 2'b00, i[0]});
      pgood <= i[2]; brst_n <= i[3];
      repeat (2) @(posedge clk);
      chk(wdt_r, i[1] ? !i[2] : !i[3]);
      chk(hwm_r, i[0] ? !i[3] : !i[2]);
    end
    // Sticky flags, global gate and write-one-clear
    apb(1'b1, IDX_EN_ONE, 8'h7F); apb(1'b1, IDX_EN_TWO, 8'h3F); apb(1'b1, IDX_ROUTE, 8'h00);
    apb(1'b1, IDX_GLOBAL, 8'h01);
    v = rnd() | 8'h01; v2 = rnd();
    src1 <= v[6:0]; src2 <= v2[5:0];
    repeat (3) @(posedge clk);
    src1 <= 7'h00; src2 <= 6'h00;
    rchk(IDX_STAT_ONE, {1'b0, v[6:0]});
    rchk(IDX_STAT_TWO, {2'b00, v2[5:0]});
    chk(pme_n, 1'b0);
    apb(1'b1, IDX_GLOBAL, 8'h00);
    // PME is registered: the gate shows one edge after the write lands
    @(posedge clk);
    chk(pme_n, 1'b1);
    apb(1'b1, IDX_STAT_ONE, 8'hFF); apb(1'b1, IDX_STAT_TWO, 8'hFF);
    rchk(IDX_STAT_ONE, 8'h00);
    rchk(IDX_STAT_TWO, 8'h00);
    // Only an enabled source may pull PME
    apb(1'b1, IDX_EN_ONE, 8'h01); apb(1'b1, IDX_EN_TWO, 8'h00); apb(1'b1, IDX_GLOBAL, 8'h01);
    src1 <= 7'h02; repeat (3) @(posedge clk);
    chk(pme_n, 1'b1);
    src1 <= 7'h03; repeat (3) @(posedge clk);
    chk(pme_n, 1'b0);
    src1 <= 7'h00; apb(1'b1, IDX_EN_ONE, 8'h00); apb(1'b1, IDX_STAT_ONE, 8'h7F);
    apb(1'b0, IDX_IRQ_STAT, 8'h00);
    apb(1'b1, IDX_IRQ_MASK, 8'h05);
    // Each general input routed to PME, then to the power switch
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, IDX_ROUTE, 8'h01 << k);
      t0 = pmel; gev <= 3'b001 << k; @(posedge clk); gev <= 3'b000;
      repeat (4) @(posedge clk);
      chk(pmel - t0, 1);
      apb(1'b1, IDX_ROUTE, 8'h10 << k);
      gev <= 3'b001 << k; @(posedge clk); gev <= 3'b000; t0 = cyc;
      psw_chk(1);
    end
    apb(1'b0, IDX_IRQ_STAT, 8'h00);
    // Delayed power-on after power loss, with the start event masked then unmasked
    apb(1'b1, IDX_POLICY, 8'h20); apb(1'b1, IDX_WAKE_SEL, 8'h10);
    pret <= 1'b1; @(posedge clk); pret <= 1'b0; t0 = cyc;
    psw_chk(DLY);
    chk(irq, 1'b0);
    apb(1'b1, IDX_IRQ_MASK, 8'h07);
    chk(irq, 1'b1);
    rchk(IDX_IRQ_STAT, 8'h02);
    chk(irq, 1'b0);
    // Dedicated wake key
    apb(1'b1, IDX_WAKE_SEL, 8'h20); apb(1'b1, IDX_CTRL, 8'h01);
    osk <= 1'b1; @(posedge clk); osk <= 1'b0; t0 = cyc;
    psw_chk(1);
    // One-key combinations of set two and set three
    for (int s = 0; s < 2; s++)
    begin
      v = rnd() | 8'h01;
      apb(1'b1, IDX_KBD_INDEX, s ? 8'h40 : 8'h30); apb(1'b1, IDX_KBD_DATA, v);
      apb(1'b1, IDX_KBD_INDEX, s ? 8'h41 : 8'h31); apb(1'b1, IDX_KBD_DATA, 8'h00);
      apb(1'b1, IDX_WAKE_SEL, s ? 8'h80 : 8'h40);
      kcode <= v; kv <= 1'b1; @(posedge clk); kv <= 1'b0; t0 = cyc;
      psw_chk(2);
    end
    // Three routed inputs, one delayed start, one wake key, two combinations: no spurious pulses
    chk(falls, 7);
    wrap_up();
  end
endmodule : acpi_pme_wake_control_test
`default_nettype wire
